// ==== ring_protection_switching_tb_top.sv ====
// self-checking bench for the ring protection controller
// assumes guard and wait-to-restore shortened to zero through registers
`timescale 1ns/1ps
`default_nettype none
module ring_protection_switching_tb_top;
    import rps_pkg::*;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    rps_bus_t i_bus = '0;
    logic [3:0] i_port_fail = 4'h0;
    rps_frame_t i_frame = '0;
    rps_raps_t i_raps;
    logic [31:0] o_rdata;
    logic o_drop;
    logic o_cfg_err;
    logic [9:0] o_tx_msg;
    logic [1:0] o_tx_req;
    logic [3:0] o_port_block;
    logic [31:0] rv;
    int err_total = 0;
    int compares = 0;
    always #2 i_clk = ~i_clk;
    rps_ctrl dut (.i_clk, .i_rst_n, .i_bus, .o_rdata, .i_port_fail, .i_raps, .i_frame, .o_drop,
        .o_tx_msg, .o_tx_req, .o_port_block, .o_cfg_err);
    rps_peer peer (.i_clk, .o_raps(i_raps));
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge i_clk);
        i_bus.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge i_clk);
        i_bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
        @(posedge i_clk);
        i_bus.rd <= 1'b0;
        #1 rv = o_rdata;
    endtask
    task automatic frame(input logic [11:0] vid, input logic raps, input logic right, input logic exp);
        @(posedge i_clk);
        i_frame <= '{valid: 1'b1, vid: vid, is_raps: raps, port_right: right, ring: 2'h0};
        @(posedge i_clk);
        i_frame.valid <= 1'b0;
        #1 chk("drop", {31'h0, o_drop}, {31'h0, exp});
    endtask
    // zero wait-to-restore expires on the first pending cycle, no tick needed
    task automatic wait_tx(input logic [4:0] exp);
        int n;
        n = 0;
        do begin
            @(posedge i_clk);
            #1 n++;
        end while (o_tx_req[0] !== 1'b1 && n < 64);
        chk("tx req", {30'h0, o_tx_req}, 32'h0000_0001);
        chk("tx msg", {27'h0, o_tx_msg[4:0]}, {27'h0, exp});
    endtask
    task automatic t_reset_vals;
        rd(8'h04);
        chk("ring0 cfg", rv, 32'h0000_0011);
        rd(8'h24);
        chk("timer", rv, 32'h0000_01F4);
        rd(8'h28);
        chk("unmapped", rv, 32'h0000_0000);
    endtask
    task automatic t_instance;
        wr(8'h00, 32'h0000_0001);
        wr(8'h04, 32'h0010_0033);
        wr(8'h0C, 32'h0011_0050);
        // the error flag reaches the pin one cycle after the write lands
        @(posedge i_clk);
        #1 chk("cfg err set", {31'h0, o_cfg_err}, 32'h1);
        wr(8'h0C, 32'h0010_0050);
        @(posedge i_clk);
        #1 chk("cfg err clr", {31'h0, o_cfg_err}, 32'h0);
        rd(8'h0C);
        chk("instance", rv, 32'h0010_0050);
        chk("idle block", {28'h0, o_port_block}, 32'h2);
    endtask
    task automatic t_drop;
        frame(12'h050, 1'b0, 1'b1, 1'b1);
        frame(12'h010, 1'b1, 1'b1, 1'b0);
        frame(12'h010, 1'b0, 1'b0, 1'b1);
        frame(12'h050, 1'b0, 1'b0, 1'b0);
        wr(8'h04, 32'h0010_003B);
        frame(12'h050, 1'b0, 1'b1, 1'b1);
        frame(12'h060, 1'b0, 1'b1, 1'b0);
    endtask
    task automatic t_fail;
        wr(8'h24, 32'h0000_0000);
        wr(8'h1C, 32'h0000_0000);
        i_port_fail <= 4'h1;
        wait_tx(5'h04);
        repeat (3) @(posedge i_clk);
        #1 chk("fail block", {28'h0, o_port_block}, 32'h1);
        rd(8'h1C);
        chk("protect", {29'h0, rv[2:0]}, 32'h1);
        @(posedge i_clk);
        i_port_fail <= 4'h0;
        wait_tx(5'h18);
        repeat (3) @(posedge i_clk);
        #1 chk("revert block", {28'h0, o_port_block}, 32'h2);
    endtask
    task automatic t_forced;
        wr(8'h14, 32'h0000_0001);
        peer.send(5'h01, 2'h0, 2);
        wr(8'h14, 32'h0000_0004);
        rd(8'h1C);
        chk("fs count", {16'h0, rv[15:8], 5'h0, rv[2:0]}, 32'h0000_0103);
        chk("fs open", {28'h0, o_port_block}, 32'h0);
    endtask
    task automatic complete_run;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge i_clk);
        i_rst_n <= 1'b1;
        t_reset_vals();
        t_instance();
        t_drop();
        t_fail();
        t_forced();
        complete_run();
    end
    // the tests take under a hundred cycles; this bounds a hang at 2000
    initial begin
        #8_000;
        err_total++;
        complete_run();
    end
endmodule
`default_nettype wire

// ==== rps_ctrl.sv ====
// ring protection switching controller for up to two rings
// assumes ring port link status and message digests synchronous to i_clk
`timescale 1ns/1ps
`default_nettype none
`include "rps_map.svh"

module rps_ctrl (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // register port
    input wire rps_pkg::rps_bus_t i_bus,
    output logic [31:0] o_rdata,
    // ring port link state, bit 0 left, bit 1 right, per ring
    input wire logic [3:0] i_port_fail,
    // received ring messages
    input wire rps_pkg::rps_raps_t i_raps,
    // frame drop query
    input wire rps_pkg::rps_frame_t i_frame,
    output logic o_drop,
    // transmit request: {ring1, ring0}, each {nr, rb, sf, fs, ms}
    output logic [9:0] o_tx_msg,
    output logic [1:0] o_tx_req,
    // port blocking, bit 2*ring + side
    output logic [3:0] o_port_block,
    output logic o_cfg_err
);
    import rps_pkg::*;

    localparam int NR = 2;
    localparam int TICKW = 18;

    logic [31:0] glob_r;
    logic [31:0] ring_r [NR];
    logic [31:0] inst_r [NR];
    logic [31:0] wtr_ms_r;
    logic [15:0] guard_ms_r;
    logic [15:0] hold_ms_r;
    logic [TICKW-1:0] tick_cnt_r;
    logic tick_r;
    logic [3:0] fail_rep_r;
    logic cfg_err_r;

    function automatic logic [31:0] reg_word(input logic [7:0] a, input logic [7:0] base);
        reg_word = {24'h00_0000, a - base};
    endfunction

    function automatic logic vlan_hit(input logic [31:0] inst, input logic [11:0] vid);
        // instance: control VLAN in 27:16, data VLAN in 11:0
        vlan_hit = (inst[11:0] == vid) && (vid != 12'h000);
    endfunction

    // fixed millisecond tick shared by all timer sets
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tick_cnt_r <= '0;
            tick_r <= 1'b0;
        end else if (tick_cnt_r == TICKW'(`RPS_TICK_CYC - 1)) begin
            tick_cnt_r <= '0;
            tick_r <= 1'b1;
        end else begin
            tick_cnt_r <= tick_cnt_r + 1'b1;
            tick_r <= 1'b0;
        end
    end

    // hold-off per port: re-check the level when it expires
    logic [15:0] hold_cnt_r [4];
    genvar gp;
    generate
        for (gp = 0; gp < 4; gp++) begin : g_hold
            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    hold_cnt_r[gp] <= '0;
                    fail_rep_r[gp] <= 1'b0;
                end else if (!i_port_fail[gp]) begin
                    hold_cnt_r[gp] <= '0;
                    fail_rep_r[gp] <= 1'b0;
                end else if (!fail_rep_r[gp]) begin
                    // reported only if the fault outlives the delay
                    if (hold_cnt_r[gp] >= hold_ms_r)
                        fail_rep_r[gp] <= 1'b1;
                    else if (tick_r)
                        hold_cnt_r[gp] <= hold_cnt_r[gp] + 1'b1;
                end
            end
        end
    endgenerate

    // register writes
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            glob_r <= '0;
            ring_r[0] <= `RPS_RING_RST;
            ring_r[1] <= `RPS_RING_RST;
            inst_r[0] <= '0;
            inst_r[1] <= '0;
            wtr_ms_r <= `RPS_WTR_RST;
            guard_ms_r <= `RPS_GUARD_RST;
            hold_ms_r <= `RPS_HOLD_RST;
            cfg_err_r <= 1'b0;
        end else if (i_bus.wr) begin
            unique case (i_bus.addr)
                `RPS_REG_GLOBAL: glob_r <= {31'h0000_0000, i_bus.wdata[0]};
                `RPS_REG_RING0: ring_r[0] <= i_bus.wdata;
                `RPS_REG_RING1: ring_r[1] <= i_bus.wdata;
                `RPS_REG_INST0, `RPS_REG_INST1: begin
                    // instance must share the ring control VLAN
                    if (i_bus.wdata[27:16] != ring_r[i_bus.addr == `RPS_REG_INST1][27:16]) begin
                        cfg_err_r <= 1'b1;
                    end else begin
                        cfg_err_r <= 1'b0;
                        inst_r[i_bus.addr == `RPS_REG_INST1] <= i_bus.wdata;
                    end
                end
                `RPS_REG_TIMER: begin
                    guard_ms_r <= i_bus.wdata[15:0];
                    hold_ms_r <= i_bus.wdata[31:16];
                end
                `RPS_REG_STAT0: wtr_ms_r <= i_bus.wdata;
                default: ;
            endcase
        end
    end

    // per-ring protection state
    rps_state_t st_r [NR];
    logic [31:0] wtr_cnt_r [NR];
    logic [15:0] guard_cnt_r [NR];
    logic [15:0] wtb_cnt_r [NR];
    logic [NR-1:0] wtr_run_r, wtb_run_r, rpl_open_r;
    logic [7:0] fs_cnt_r [NR];
    logic [4:0] tx_msg_r [NR];
    logic [NR-1:0] tx_req_r;

    genvar gr;
    generate
        for (gr = 0; gr < NR; gr++) begin : g_ring
            logic en, owner, neigh, revert, rside;
            logic loc_sf, rpl_fail, guard_on, raps_ok, cmd_wr, fs_cmd, ms_cmd, clr_cmd;
            assign en = glob_r[0] & ring_r[gr][`RPS_F_EN];
            assign owner = ring_r[gr][`RPS_F_OWNER];
            assign neigh = ring_r[gr][`RPS_F_NEIGH];
            assign revert = ring_r[gr][`RPS_F_REVERT];
            assign rside = ring_r[gr][`RPS_F_RPL_RIGHT];
            assign loc_sf = |fail_rep_r[2*gr +: 2];
            assign rpl_fail = fail_rep_r[2*gr + rside];
            assign guard_on = guard_cnt_r[gr] != '0;
            // messages only act once guard has run out
            assign raps_ok = i_raps.valid && i_raps.ring == 2'(gr) && !guard_on;
            assign cmd_wr = i_bus.wr && i_bus.addr == (gr == 0 ? `RPS_REG_CMD0 : `RPS_REG_CMD1);
            assign fs_cmd = cmd_wr && i_bus.wdata[`RPS_F_FS];
            assign ms_cmd = cmd_wr && i_bus.wdata[`RPS_F_MS];
            assign clr_cmd = cmd_wr && i_bus.wdata[`RPS_F_CLR];

            // guard: loaded on a local forced or manual command, or on a local fault while idle; no stop path
            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n)
                    guard_cnt_r[gr] <= '0;
                else if (en && (fs_cmd || ms_cmd || (loc_sf && st_r[gr] == RPS_IDLE)))
                    guard_cnt_r[gr] <= guard_ms_r;
                else if (tick_r && guard_on)
                    guard_cnt_r[gr] <= guard_cnt_r[gr] - 1'b1;
            end

            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    st_r[gr] <= RPS_IDLE;
                    wtr_cnt_r[gr] <= '0;
                    wtb_cnt_r[gr] <= '0;
                    wtr_run_r[gr] <= 1'b0;
                    wtb_run_r[gr] <= 1'b0;
                    rpl_open_r[gr] <= 1'b0;
                    fs_cnt_r[gr] <= '0;
                    tx_msg_r[gr] <= '0;
                    tx_req_r[gr] <= 1'b0;
                end else if (!en) begin
                    st_r[gr] <= RPS_IDLE;
                    rpl_open_r[gr] <= 1'b0;
                    wtr_run_r[gr] <= 1'b0;
                    wtb_run_r[gr] <= 1'b0;
                    fs_cnt_r[gr] <= '0;
                    tx_req_r[gr] <= 1'b0;
                end else begin
                    tx_req_r[gr] <= 1'b0;
                    unique case (st_r[gr])
                        RPS_IDLE: begin
                            rpl_open_r[gr] <= 1'b0;
                            if (fs_cmd || (raps_ok && i_raps.fs)) begin
                                st_r[gr] <= RPS_FORCED;
                                fs_cnt_r[gr] <= 8'h01;
                            end else if (ms_cmd || (raps_ok && i_raps.ms)) begin
                                st_r[gr] <= RPS_MANUAL;
                            end else if (loc_sf || (raps_ok && i_raps.sf)) begin
                                st_r[gr] <= RPS_PROTECT;
                            end
                        end
                        RPS_PROTECT: begin
                            // open the spare link unless it is itself the failure
                            rpl_open_r[gr] <= !rpl_fail;
                            if (fs_cmd) begin
                                st_r[gr] <= RPS_FORCED;
                                fs_cnt_r[gr] <= 8'h01;
                            end else if (!loc_sf && !(raps_ok && i_raps.sf)) begin
                                if (revert && owner) begin
                                    st_r[gr] <= RPS_PENDING;
                                    wtr_run_r[gr] <= 1'b1;
                                    wtr_cnt_r[gr] <= wtr_ms_r;
                                end else if (!revert) begin
                                    st_r[gr] <= RPS_PENDING;
                                end
                            end
                        end
                        RPS_FORCED: begin
                            rpl_open_r[gr] <= !rpl_fail;
                            if (fs_cmd || (raps_ok && i_raps.fs))
                                fs_cnt_r[gr] <= fs_cnt_r[gr] + 1'b1;
                            else if (clr_cmd && fs_cnt_r[gr] != '0)
                                fs_cnt_r[gr] <= fs_cnt_r[gr] - 1'b1;
                            // only the last clear lets recovery start
                            if (clr_cmd && fs_cnt_r[gr] == 8'h01 && owner) begin
                                st_r[gr] <= RPS_PENDING;
                                wtb_run_r[gr] <= 1'b1;
                                wtb_cnt_r[gr] <= 16'(`RPS_WTB_MS);
                            end
                        end
                        RPS_MANUAL: begin
                            rpl_open_r[gr] <= !rpl_fail;
                            if (fs_cmd) begin
                                st_r[gr] <= RPS_FORCED;
                                fs_cnt_r[gr] <= 8'h01;
                            end else if (loc_sf) begin
                                st_r[gr] <= RPS_PROTECT;
                            end else if (clr_cmd && owner) begin
                                st_r[gr] <= RPS_PENDING;
                                wtb_run_r[gr] <= 1'b1;
                                wtb_cnt_r[gr] <= 16'(`RPS_WTB_MS);
                            end
                        end
                        RPS_PENDING: begin
                            // stale remote manual requests are ignored here
                            if (fs_cmd || (raps_ok && i_raps.fs)) begin
                                st_r[gr] <= RPS_FORCED;
                                fs_cnt_r[gr] <= 8'h01;
                                wtr_run_r[gr] <= 1'b0;
                                wtb_run_r[gr] <= 1'b0;
                            end else if (loc_sf || (raps_ok && i_raps.sf)) begin
                                st_r[gr] <= RPS_PROTECT;
                                wtr_run_r[gr] <= 1'b0;
                                wtb_run_r[gr] <= 1'b0;
                            end else if (wtr_run_r[gr]) begin
                                if (wtr_cnt_r[gr] == '0) begin
                                    // re-block and announce in the same cycle
                                    wtr_run_r[gr] <= 1'b0;
                                    st_r[gr] <= RPS_IDLE;
                                    rpl_open_r[gr] <= 1'b0;
                                    tx_msg_r[gr] <= 5'b1_1000;
                                    tx_req_r[gr] <= 1'b1;
                                end else if (tick_r) begin
                                    wtr_cnt_r[gr] <= wtr_cnt_r[gr] - 1'b1;
                                end
                            end else if (wtb_run_r[gr]) begin
                                if (wtb_cnt_r[gr] == '0) begin
                                    wtb_run_r[gr] <= 1'b0;
                                    st_r[gr] <= RPS_IDLE;
                                    rpl_open_r[gr] <= 1'b0;
                                    tx_msg_r[gr] <= 5'b1_1000;
                                    tx_req_r[gr] <= 1'b1;
                                end else if (tick_r) begin
                                    wtb_cnt_r[gr] <= wtb_cnt_r[gr] - 1'b1;
                                end
                            end else if (raps_ok && i_raps.nr && i_raps.rb) begin
                                // non-revertive node, owner or not: follow the owner's block
                                st_r[gr] <= RPS_IDLE;
                                rpl_open_r[gr] <= 1'b0;
                            end
                        end
                        default: st_r[gr] <= RPS_IDLE;
                    endcase
                    if (loc_sf && st_r[gr] == RPS_IDLE) begin
                        tx_msg_r[gr] <= 5'b0_0100;
                        tx_req_r[gr] <= 1'b1;
                    end
                end
            end
        end
    endgenerate

    // port blocking and frame filter
    logic [3:0] blk_nxt;
    always_comb begin
        blk_nxt = '0;
        for (int r = 0; r < NR; r++) begin
            for (int s = 0; s < 2; s++) begin
                if (glob_r[0] && ring_r[r][`RPS_F_EN]) begin
                    // owner or neighbour holds the spare end shut
                    if ((ring_r[r][`RPS_F_OWNER] || ring_r[r][`RPS_F_NEIGH])
                        && s == int'(ring_r[r][`RPS_F_RPL_RIGHT]) && !rpl_open_r[r])
                        blk_nxt[2*r+s] = 1'b1;
                    if (fail_rep_r[2*r+s])
                        blk_nxt[2*r+s] = 1'b1;
                end
            end
        end
    end

    logic drop_nxt;
    always_comb begin
        logic [1:0] r;
        logic [11:0] cvid;
        r = i_frame.ring;
        cvid = ring_r[r[0]][27:16];
        drop_nxt = 1'b0;
        if (i_frame.valid && glob_r[0] && ring_r[r[0]][`RPS_F_EN]) begin
            // control VLAN admits protection frames only
            if (i_frame.vid == cvid && !i_frame.is_raps)
                drop_nxt = 1'b1;
            if (blk_nxt[2*r[0] + i_frame.port_right] && !i_frame.is_raps) begin
                if (!ring_r[r[0]][`RPS_F_V2])
                    drop_nxt = 1'b1;
                else if (vlan_hit(inst_r[r[0]], i_frame.vid))
                    drop_nxt = 1'b1;
            end
        end
    end

    // outputs all registered
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_port_block <= '0;
            o_drop <= 1'b0;
            o_tx_msg <= '0;
            o_tx_req <= '0;
            o_cfg_err <= 1'b0;
        end else begin
            o_port_block <= blk_nxt;
            o_drop <= drop_nxt;
            o_tx_msg <= {tx_msg_r[1], tx_msg_r[0]};
            o_tx_req <= tx_req_r;
            o_cfg_err <= cfg_err_r;
        end
    end

    // read data one cycle after the strobe, unmapped reads zero
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= '0;
        end else if (i_bus.rd) begin
            unique case (i_bus.addr)
                `RPS_REG_GLOBAL: o_rdata <= glob_r;
                `RPS_REG_RING0: o_rdata <= ring_r[0];
                `RPS_REG_RING1: o_rdata <= ring_r[1];
                `RPS_REG_INST0: o_rdata <= inst_r[0];
                `RPS_REG_INST1: o_rdata <= inst_r[1];
                `RPS_REG_STAT0, `RPS_REG_STAT1: o_rdata <= {16'h0000, fs_cnt_r[i_bus.addr == `RPS_REG_STAT1],
                    1'b0, cfg_err_r, rpl_open_r[i_bus.addr == `RPS_REG_STAT1],
                    2'b00, 3'(st_r[i_bus.addr == `RPS_REG_STAT1])};
                `RPS_REG_TIMER: o_rdata <= {hold_ms_r, guard_ms_r};
                default: o_rdata <= reg_word(8'h00, 8'h00);
            endcase
        end else begin
            o_rdata <= '0;
        end
    end
endmodule
`default_nettype wire

// ==== rps_ctrl_chk.sv ====
// assertions on the ring protection controller ports
// assumes one clock domain and an async active-low reset
`timescale 1ns/1ps
`default_nettype none
module rps_ctrl_chk (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // watched ports
    input wire rps_pkg::rps_bus_t i_bus,
    input wire logic [31:0] o_rdata,
    input wire logic [3:0] i_port_fail,
    input wire rps_pkg::rps_frame_t i_frame,
    input wire logic o_drop,
    input wire logic [9:0] o_tx_msg,
    input wire logic [1:0] o_tx_req,
    input wire logic [3:0] o_port_block,
    input wire logic o_cfg_err
);
    import rps_pkg::*;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    a_rdata_quiet: assert property (!$past(i_bus.rd) |-> o_rdata == 32'h0000_0000)
        else $error("read data outside read answer");
    a_tx0_msg_kind: assert property (o_tx_req[0] |-> o_tx_msg[4:0] inside {5'h18, 5'h04})
        else $error("ring0 message kind wrong");
    a_tx0_pulse: assert property (o_tx_req[0] |=> !o_tx_req[0])
        else $error("ring0 send request longer than one cycle");
    a_tx1_msg_kind: assert property (o_tx_req[1] |-> o_tx_msg[9:5] inside {5'h18, 5'h04})
        else $error("ring1 message kind wrong");
    a_cfg_err_set: assert property ($rose(o_cfg_err) |-> $past(i_bus.wr, 2) && $past(i_bus.addr, 2) inside {8'h0C, 8'h10})
        else $error("config error rose without instance write");
    a_cfg_err_clear: assert property ($fell(o_cfg_err) |-> $past(i_bus.wr, 2) && $past(i_bus.addr, 2) inside {8'h0C, 8'h10})
        else $error("config error fell without instance write");
    a_raps_kept: assert property ($past(i_frame.valid && i_frame.is_raps) |-> !o_drop)
        else $error("protection frame dropped");
    a_fault_shown: assert property (i_port_fail[0] [*3] |=> o_port_block[0])
        else $error("lasting port fault not blocked");
endmodule
bind rps_ctrl rps_ctrl_chk u_chk (.i_clk, .i_rst_n, .i_bus, .o_rdata, .i_port_fail, .i_frame, .o_drop,
    .o_tx_msg, .o_tx_req, .o_port_block, .o_cfg_err);
`default_nettype wire

// ==== rps_map.svh ====
// ring protection switching: register offsets, field positions, reset values, timing counts
// assumes a 250 MHz core clock and a 1 ms timer tick
`ifndef RPS_MAP_SVH
`define RPS_MAP_SVH

`define RPS_CLK_HZ 250_000_000
`define RPS_TICK_MS 1
`define RPS_TICK_CYC ((`RPS_CLK_HZ / 1000) * `RPS_TICK_MS)
`define RPS_WTR_S 300
`define RPS_WTR_MS (`RPS_WTR_S * 1000)
`define RPS_GUARD_MS 500
`define RPS_WTB_EXTRA_S 5
`define RPS_WTB_MS (`RPS_GUARD_MS + `RPS_WTB_EXTRA_S * 1000)
`define RPS_HOLDOFF_MS 0
`define RPS_SWITCH_MS 800

// register byte addresses, four times the register index
`define RPS_REG_GLOBAL 8'h00
`define RPS_REG_RING0 8'h04
`define RPS_REG_RING1 8'h08
`define RPS_REG_INST0 8'h0C
`define RPS_REG_INST1 8'h10
`define RPS_REG_CMD0 8'h14
`define RPS_REG_CMD1 8'h18
`define RPS_REG_STAT0 8'h1C
`define RPS_REG_STAT1 8'h20
`define RPS_REG_TIMER 8'h24

// ring config fields
`define RPS_F_EN 0
`define RPS_F_OWNER 1
`define RPS_F_NEIGH 2
`define RPS_F_V2 3
`define RPS_F_REVERT 4
`define RPS_F_RPL_RIGHT 5
`define RPS_F_CVID_LO 16

// command fields
`define RPS_F_FS 0
`define RPS_F_MS 1
`define RPS_F_CLR 2

`define RPS_RING_RST 32'h0000_0011
`define RPS_WTR_RST 32'h0004_93E0
`define RPS_GUARD_RST 16'h01F4
`define RPS_HOLD_RST 16'h0000
`endif

// ==== rps_peer.sv ====
// peer ring node model: hands received message digests to the controller
// assumes the bench calls send, one message at a time
`timescale 1ns/1ps
`default_nettype none
module rps_peer (
    // clock
    input wire logic i_clk,
    // digest toward the controller
    output var rps_pkg::rps_raps_t o_raps
);
    import rps_pkg::*;
    initial o_raps = '0;
    // lag gives a slow peer; idle fields are inverted so stale data never matches
    task automatic send(input logic [4:0] msg, input logic [1:0] ring, input int lag);
        repeat (lag) @(posedge i_clk);
        o_raps <= {1'b1, msg, ring};
        @(posedge i_clk);
        o_raps <= {1'b0, ~msg, ~ring};
    endtask
endmodule
`default_nettype wire

// ==== rps_pkg.sv ====
// ring protection switching: shared types
// used by the controller and by its testbench
`default_nettype none
package rps_pkg;
    typedef enum logic [2:0] {
        RPS_IDLE,
        RPS_PROTECT,
        RPS_MANUAL,
        RPS_FORCED,
        RPS_PENDING
    } rps_state_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } rps_bus_t;

    // received message digest from the ring ports
    typedef struct packed {
        logic valid;
        logic nr;
        logic rb;
        logic sf;
        logic ms;
        logic fs;
        logic [1:0] ring;
    } rps_raps_t;

    // frame classification per ring port
    typedef struct packed {
        logic valid;
        logic [11:0] vid;
        logic is_raps;
        logic port_right;
        logic [1:0] ring;
    } rps_frame_t;
endpackage
`default_nettype wire
